// File: hdl/fpcsr_pkg.sv
// constants and types for the coprocessor control/status register pair
// Behaviour
// RULE_01 - bit 23 holds compare result
// RULE_02 - condition changes only by compare or write
// RULE_03 - condition drives core branch input one
// RULE_04 - bits 17:12 reflect last operation
// RULE_05 - six flags: unimpl, invalid, div0, ovf, unf, inexact
// RULE_06 - multiple exceptions set all flags
// RULE_07 - exception sets flag and sticky bit; the code keeps no sticky bit for unimplemented, only its flag is set
// RULE_08 - sticky bits 6:2 cleared only by write
// RULE_09 - enables 11:7 raise trap line
// RULE_10 - unimplemented operation always traps
// RULE_11 - core takes interrupt on trap line
// RULE_12 - bits 1:0 select rounding mode
// RULE_13 - read drains pipeline before answering
// RULE_14 - exception during drain taken, read retried
// RULE_15 - software writes only when pipeline idle
// RULE_16 - register open to user and kernel
// RULE_17 - reserved bits written zero, read undefined
// RULE_18 - register zero: implementation and revision
// RULE_19 - write loads all fields from word
// RULE_20 - only control registers 31 and 0 exist
package fpcsr_pkg;
    localparam logic [4:0] REG_IMP_REV = 5'h00;
    localparam logic [4:0] REG_CTRL_STATUS = 5'h1F;
    localparam int COND_BIT = 23;
    localparam int EXC_LSB = 12;
    localparam int EN_LSB = 7;
    localparam int STICKY_LSB = 2;
    localparam int RM_LSB = 0;
    localparam int IMP_LSB = 8;
    localparam int REV_LSB = 0;
    // writable bits of the control/status word
    localparam logic [31:0] CSR_WMASK = 32'h0083_FFFF;
    localparam logic [31:0] CSR_RESET = 32'h0000_0000;
    localparam logic [7:0] IMP_CODE = 8'h5A; // arbitrary value
    localparam logic [7:0] REV_CODE = 8'h01; // arbitrary value
    // exception vector index: e v z o u i
    localparam int X_INEXACT = 0;
    localparam int X_UNDER = 1;
    localparam int X_OVER = 2;
    localparam int X_DIVZ = 3;
    localparam int X_INVALID = 4;
    localparam int X_UNIMPL = 5;
    typedef enum logic [1:0] {
        NEAREST_EVEN, TOWARD_ZERO, TOWARD_PLUS_INF, TOWARD_MINUS_INF
    } round_select_t;
    typedef enum logic [1:0] {
        ST_IDLE, ST_DRAIN, ST_ANSWER
    } rd_state_t;
endpackage

// File: hdl/fpcsr_if.sv
// link between integer core and floating-point control registers
`timescale 1ns/1ns
`default_nettype none
interface fpcsr_if;
    logic mv_to;        // move_control_to_fp strobe
    logic mv_from;      // move_control_from_fp strobe
    logic [4:0] creg;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic rvalid;       // read answered
    logic rretry;       // read aborted by exception, re-issue
    logic coproc_condition_out;
    logic coproc_trap_request_n;
    modport device (input mv_to, mv_from, creg, wdata,
        output rdata, rvalid, rretry, coproc_condition_out,
        coproc_trap_request_n);
    modport core (output mv_to, mv_from, creg, wdata,
        input rdata, rvalid, rretry, coproc_condition_out,
        coproc_trap_request_n);
endinterface
`default_nettype wire

// File: hdl/fp_trap_gen.sv
// trap request from new exception flags and enables
`timescale 1ns/1ns
`default_nettype none
module fp_trap_gen (
    input wire logic [5:0] exc_i,
    input wire logic [4:0] enable_i,
    output logic trap_o
);
    // unimplemented has no enable
    assign trap_o = exc_i[fpcsr_pkg::X_UNIMPL] // RULE_10
        | (|(exc_i[4:0] & enable_i)); // RULE_09
endmodule // fp_trap_gen
`default_nettype wire

// File: hdl/fp_control_status_regs.sv
// coprocessor end: control/status and implementation registers
`timescale 1ns/1ns
`default_nettype none
module fp_control_status_regs (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    fpcsr_if.device bus,
    input wire logic op_done_i,
    input wire logic op_is_compare_i,
    input wire logic compare_true_i,
    input wire logic [5:0] op_exc_i,
    input wire logic pipe_busy_i,
    output logic [1:0] round_select_o,
    output logic float_trap_line_o
);
    typedef struct packed {
        logic [31:0] csr;
        logic trap;
        logic [31:0] rdata;
        logic rvalid;
        logic rretry;
        fpcsr_pkg::rd_state_t st;
        logic [4:0] reg_sel;
    } state_t;
    state_t s, next_s;
    logic trap_new;
    logic csr_write;
    logic [31:0] csr_written;
    wire logic [5:0] next_exc;
    wire logic [4:0] next_sticky;
    logic next_cond;
    logic next_trap;
    logic drain_done;
    logic drain_abort;

    fp_trap_gen trap_gen (
        .exc_i(op_exc_i),
        .enable_i(s.csr[fpcsr_pkg::EN_LSB +: 5]),
        .trap_o(trap_new)
    );

    // a move-to reaches only the control/status word
    assign csr_write = bus.mv_to
        && (bus.creg == fpcsr_pkg::REG_CTRL_STATUS); // RULE_20
    // reserved bits forced to zero on load
    assign csr_written = bus.wdata & fpcsr_pkg::CSR_WMASK; // RULE_17 RULE_19

    // per flag: an operation rewrites the last-instruction bit and, for all but
    // unimplemented, only adds to the sticky copy; a raise outranks a same-cycle load
    for (genvar f = 0; f < 6; f++) begin : g_flag // RULE_05
        logic raised;
        assign raised = op_done_i & op_exc_i[f]; // RULE_06 RULE_07
        assign next_exc[f] = csr_write
            ? (csr_written[fpcsr_pkg::EXC_LSB + f] | raised)
            : (op_done_i ? op_exc_i[f]
            : s.csr[fpcsr_pkg::EXC_LSB + f]); // RULE_04
        if (f < 5) begin : g_sticky
            assign next_sticky[f] = raised
                | (csr_write ? csr_written[fpcsr_pkg::STICKY_LSB + f]
                : s.csr[fpcsr_pkg::STICKY_LSB + f]); // RULE_08
        end
    end

    // a write outranks a compare in the same cycle
    assign next_cond = csr_write ? csr_written[fpcsr_pkg::COND_BIT]
        : (op_done_i && op_is_compare_i) ? compare_true_i
        : s.csr[fpcsr_pkg::COND_BIT]; // RULE_01 RULE_02
    // a fresh trap outranks the clear carried by a write
    assign next_trap = (op_done_i && trap_new)
        || (s.trap && !csr_write); // RULE_09 RULE_10
    assign drain_abort = op_done_i && trap_new; // RULE_14
    assign drain_done = !pipe_busy_i && !op_done_i; // RULE_13

    function automatic logic [31:0] read_word(input logic [4:0] r,
                                              input logic [31:0] c);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (r == fpcsr_pkg::REG_CTRL_STATUS) begin
            w = c; // RULE_16
        end else if (r == fpcsr_pkg::REG_IMP_REV) begin
            w[fpcsr_pkg::IMP_LSB +: 8] = fpcsr_pkg::IMP_CODE; // RULE_18
            w[fpcsr_pkg::REV_LSB +: 8] = fpcsr_pkg::REV_CODE;
        end
        return w;
    endfunction

    always_comb begin
        next_s = s;
        next_s.rvalid = 1'b0;
        next_s.rretry = 1'b0;
        if (csr_write) begin
            next_s.csr = csr_written; // RULE_19
        end
        next_s.csr[fpcsr_pkg::EXC_LSB +: 6] = next_exc;
        next_s.csr[fpcsr_pkg::STICKY_LSB +: 5] = next_sticky;
        next_s.csr[fpcsr_pkg::COND_BIT] = next_cond;
        next_s.trap = next_trap;
        case (s.st)
            fpcsr_pkg::ST_IDLE: begin
                if (bus.mv_from) begin
                    next_s.reg_sel = bus.creg;
                    next_s.st = fpcsr_pkg::ST_DRAIN; // RULE_13
                end
            end
            fpcsr_pkg::ST_DRAIN: begin
                if (drain_abort) begin
                    next_s.rretry = 1'b1; // RULE_14
                    next_s.st = fpcsr_pkg::ST_IDLE;
                end else if (drain_done) begin
                    next_s.st = fpcsr_pkg::ST_ANSWER;
                end
            end
            fpcsr_pkg::ST_ANSWER: begin
                next_s.rdata = read_word(s.reg_sel, s.csr); // RULE_13
                next_s.rvalid = 1'b1;
                next_s.st = fpcsr_pkg::ST_IDLE;
            end
            default: next_s.st = fpcsr_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '{csr: fpcsr_pkg::CSR_RESET, trap: 1'b0,
                   rdata: 32'h0000_0000, rvalid: 1'b0, rretry: 1'b0,
                   st: fpcsr_pkg::ST_IDLE, reg_sel: 5'h00};
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign bus.rdata = s.rdata;
    assign bus.rvalid = s.rvalid;
    assign bus.rretry = s.rretry;
    assign bus.coproc_condition_out = s.csr[fpcsr_pkg::COND_BIT]; // RULE_03
    assign bus.coproc_trap_request_n = ~s.trap;
    assign float_trap_line_o = s.trap;
    assign round_select_o = s.csr[fpcsr_pkg::RM_LSB +: 2]; // RULE_12
endmodule // fp_control_status_regs
`default_nettype wire

// File: hdl/fp_core_end.sv
// core end: issues control moves from a software port
`timescale 1ns/1ns
`default_nettype none
module fp_core_end (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    fpcsr_if.core bus,
    input wire logic [4:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic busy_o,
    output logic branch_condition_in_o,
    output logic trap_pending_o
);
    typedef struct packed {
        logic [4:0] addr;
        logic [31:0] wdata;
        logic mv_to;
        logic mv_from;
        logic [31:0] rdata;
        logic busy;
        logic trap;
        logic cond;
    } state_t;
    state_t s, next_s;

    always_comb begin
        next_s = s;
        next_s.mv_to = 1'b0;
        next_s.mv_from = 1'b0;
        next_s.cond = bus.coproc_condition_out;
        next_s.trap = ~bus.coproc_trap_request_n; // RULE_11
        if (wr_i && !s.busy) begin
            next_s.addr = addr_i;
            next_s.wdata = wdata_i; // RULE_15
            next_s.mv_to = 1'b1;
        end else if (rd_i && !s.busy) begin
            next_s.addr = addr_i;
            next_s.mv_from = 1'b1;
            next_s.busy = 1'b1;
        end
        if (bus.rvalid) begin
            next_s.rdata = bus.rdata;
            next_s.busy = 1'b0;
        end else if (bus.rretry) begin
            next_s.busy = 1'b0; // RULE_14
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '{addr: 5'h00, wdata: 32'h0000_0000, mv_to: 1'b0,
                   mv_from: 1'b0, rdata: 32'h0000_0000, busy: 1'b0,
                   trap: 1'b0, cond: 1'b0};
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign bus.mv_to = s.mv_to;
    assign bus.mv_from = s.mv_from;
    assign bus.creg = s.addr;
    assign bus.wdata = s.wdata;
    assign rdata_o = s.rdata;
    assign busy_o = s.busy;
    assign branch_condition_in_o = s.cond; // RULE_03
    assign trap_pending_o = s.trap;
endmodule // fp_core_end
`default_nettype wire

// File: test/fp_control_status_regs_assertions.sv
// interface assertions for the control register link
`timescale 1ns/1ns
`default_nettype none
module fpcsr_checker (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic mv_to,
    input wire logic mv_from,
    input wire logic [4:0] creg,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rretry,
    input wire logic coproc_condition_out,
    input wire logic coproc_trap_request_n
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    property p_cond;
        (mv_to && creg == 5'h1F) |=>
            coproc_condition_out == $past(wdata[23]);
    endproperty
    AST_READ_ANSWERED: assert property (mv_from |-> ##[3:200]
        (rvalid || rretry)) else $error("read not answered");
    AST_NO_EARLY_ANSWER: assert property (mv_from |=>
        !rvalid ##1 !rvalid) else $error("read answered too early");
    AST_ANSWER_ONE_CYCLE: assert property (rvalid |=> !rvalid)
        else $error("read answer longer than one cycle");
    AST_VALID_OR_RETRY: assert property (!(rvalid && rretry))
        else $error("answer and retry together");
    AST_IMP_REV: assert property ((mv_from && creg == 5'h00) |->
        ##[3:200] rvalid && rdata == {16'h0000, fpcsr_pkg::IMP_CODE,
        fpcsr_pkg::REV_CODE}) else $error("wrong implementation word");
    AST_RESERVED_ZERO: assert property (rvalid |-> rdata[31:24] == 8'h00
        && rdata[22:18] == 5'h00) else $error("reserved bits not zero");
    AST_COND_FROM_WRITE: assert property (p_cond)
        else $error("condition not loaded by write");
    AST_TRAP_CLEARED: assert property ((mv_to && creg == 5'h1F) |->
        ##[1:2] coproc_trap_request_n) else $error("trap not cleared");
    cover property (mv_to && creg == 5'h1F);
    cover property (rvalid && creg == 5'h00);
    cover property (!coproc_trap_request_n);
    cover property (rretry);
endmodule // fpcsr_checker
`default_nettype wire

// File: test/fp_control_status_regs_tb_top.sv
// self-checking bench for both ends of the control register link
`timescale 1ns/1ns
`default_nettype none
module fp_control_status_regs_tb_top;
    logic mclk_i = '0, rst_i = '1, wr_i = '0, rd_i = '0, op_done_i = '0;
    logic op_is_compare_i = '0, compare_true_i = '0, pipe_busy_i = '0;
    logic c, t, busy_o, branch_condition_in_o, float_trap_line_o;
    logic trap_pending_o;
    logic trap = '0;
    logic ce_i = '1;
    logic [5:0] op_exc_i = '0, x;
    logic [4:0] addr_i = '0;
    logic [1:0] round_select_o;
    logic [31:0] wdata_i = '0, rdata_o, csr = '0, d;
    int miscompares = 0, checks_done = 0, seed = 45;
    fpcsr_if i_fpcsr_if();
    fp_control_status_regs i_fp_control_status_regs (.mclk_i(mclk_i),
        .rst_i(rst_i), .ce_i(ce_i), .bus(i_fpcsr_if.device),
        .op_done_i(op_done_i), .op_is_compare_i(op_is_compare_i),
        .compare_true_i(compare_true_i), .op_exc_i(op_exc_i),
        .pipe_busy_i(pipe_busy_i), .round_select_o(round_select_o),
        .float_trap_line_o(float_trap_line_o));
    fp_core_end i_fp_core_end (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
        .bus(i_fpcsr_if.core), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .busy_o(busy_o),
        .branch_condition_in_o(branch_condition_in_o),
        .trap_pending_o(trap_pending_o));
    fpcsr_checker i_fpcsr_checker (.mclk_i(mclk_i), .rst_i(rst_i),
        .mv_to(i_fpcsr_if.mv_to), .mv_from(i_fpcsr_if.mv_from),
        .creg(i_fpcsr_if.creg), .wdata(i_fpcsr_if.wdata),
        .rdata(i_fpcsr_if.rdata), .rvalid(i_fpcsr_if.rvalid),
        .rretry(i_fpcsr_if.rretry),
        .coproc_condition_out(i_fpcsr_if.coproc_condition_out),
        .coproc_trap_request_n(i_fpcsr_if.coproc_trap_request_n));
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("Error %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task stat;
        logic [31:0] s, e;
        repeat (4) @(posedge mclk_i);
        #1;
        s = {27'h0, round_select_o, float_trap_line_o, trap_pending_o,
            branch_condition_in_o};
        e = {27'h0, csr[1:0], trap, trap, csr[23]};
        chk(s, e);
    endtask
    task wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        wr_i <= 1'h1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge mclk_i);
        wr_i <= 1'h0;
        if (a == 5'h1F) begin
            csr = v & fpcsr_pkg::CSR_WMASK;
            trap = 1'h0;
        end
        stat;
    endtask
    task rd(input logic [4:0] a, input logic [31:0] e);
        int n;
        @(posedge mclk_i);
        rd_i <= 1'h1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'h0;
        n = 0;
        do begin
            @(posedge mclk_i);
            #1;
            n++;
        end while (busy_o !== 1'h0 && n < 60);
        chk({31'h0, busy_o}, 32'h0);
        chk(rdata_o, e);
    endtask
    task mdl;
        csr[17:12] = x;
        csr[6:2] = csr[6:2] | x[4:0];
        if (c) csr[23] = t;
        if (x[5] || |(x[4:0] & csr[11:7])) trap = 1'h1;
    endtask
    task op;
        @(posedge mclk_i);
        op_done_i <= 1'h1;
        op_is_compare_i <= c;
        compare_true_i <= t;
        op_exc_i <= x;
        @(posedge mclk_i);
        op_done_i <= 1'h0;
        pipe_busy_i <= 1'h0;
    endtask
    initial forever #5 mclk_i = ~mclk_i;
    initial begin
        #200000;
        miscompares++;
        results;
    end
    initial begin
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'h0;
        d = {16'h0000, fpcsr_pkg::IMP_CODE, fpcsr_pkg::REV_CODE};
        rd(5'h00, d);
        wr(5'h00, 32'hFFFF_FFFF);
        rd(5'h00, d);
        rd(5'h05, 32'h0);
        for (int k = 0; k < 16; k++) begin
            d = $random(seed);
            d[1:0] = k[1:0];
            wr(5'h1F, d);
            wr(5'h05, 32'h0);
            rd(5'h1F, csr);
            repeat (3) begin
                {c, t, x} = 8'($random(seed));
                mdl;
                op;
                stat;
            end
            rd(5'h1F, csr);
        end
        wr(5'h1F, 32'h0000_0003);
        {c, t, x} = 8'hC1;
        mdl;
        @(posedge mclk_i);
        pipe_busy_i <= 1'h1;
        fork
            rd(5'h1F, csr);
            begin
                repeat (4) @(posedge mclk_i);
                op;
            end
        join
        stat;
        d = csr;
        {c, t, x} = 8'h20;
        mdl;
        @(posedge mclk_i);
        pipe_busy_i <= 1'h1;
        fork
            rd(5'h1F, d);
            begin
                repeat (4) @(posedge mclk_i);
                op;
            end
        join
        stat;
        rd(5'h1F, csr);
        @(posedge mclk_i);
        ce_i <= 1'h0;
        {c, t, x} = 8'hFF;
        op;
        ce_i <= 1'h1;
        stat;
        rd(5'h1F, csr);
        results;
    end
endmodule // fp_control_status_regs_tb_top
`default_nettype wire
